// ---- lsp_cfg.sv ----
// local scan port configuration: mode registers, chain routing, clock gating, gpio, fifo
// Functional notes
// - multicast address selects only selectors whose group register matches.
// - test-logic-reset loads chain select zero with 00000001.
// - all ports parked: chain is input, internal register, output.
// - resume-ports command sets unparked chain from select registers zero and one.
// - chain: register, enabled ports ascending, pad after each, then output.
// - select zero bits 0,1,2,5,6 enable ports 0-4; 3 clock, 4 loop, 7 status.
// - select one bits 0,1 enable ports five and six; bits 2-6 reserved.
// - loopback bit forces chain input, register, output regardless of enables.
// - clock-disable zero keeps parked port clocks running in idle or pause.
// - clock-disable one stops parked port clock low while parked.
// - unparked port clocks always run.
// - port parked in reset stops its clock after 512 backplane pulses.
// - status bit sets when running counter reaches zero.
// - status bit clears on counter load, zero after power-on.
// - select one bit 7 enables transparent mode, only in bridge primary mode.
// - gpio select bits 0-6 put ports 0-6 into gpio use; bit 7 reserved.
// - gpio pins register: bit 0 mode-select, bit 1 data-out, bit 2 captures data-in.
// - all mode bits reset to zero except select zero bit 0.
// - group codes 0-3 match multicast addresses 3c-3f.
// - registers reached only by scanning through the backplane test port.
// - serial data enters at msb and leaves from lsb.
// - every gpio pins bit resets to zero.
`timescale 1ns/1ns

// =====================================================================
// configuration write fifo
module lsp_cfg_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,              // system clock
    input wire logic rst_n,                // synchronous reset, active low
    input wire logic in_valid,             // write offered
    output logic in_ready,                 // room for a write
    input wire logic [WIDTH-1:0] in_data,  // write word
    output logic out_valid,                // word waiting
    input wire logic out_ready,            // drain takes the word
    output logic [WIDTH-1:0] out_data      // head word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } lsp_fifo_st_t;

    lsp_fifo_st_t st, next_st;
    logic push, pop;

    assign in_ready = st.cnt != (AW+1)'(DEPTH);
    assign out_valid = st.cnt != '0;
    assign out_data = st.mem[st.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // lsp_cfg_fifo

// =====================================================================
// configuration top
module lsp_cfg #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic sys_clk,                        // system clock, 100 mhz
    input wire logic rst_n,                          // synchronous reset, active low
    input wire logic tck_b,                          // backplane test clock pin
    input wire logic tms_b,                          // backplane mode select pin
    input wire logic tdi_b,                          // backplane data in pin
    input wire lsp_pkg::lsp_dr_t dr_sel,             // data register chosen by instruction decode
    input wire logic [2:0] gpio_idx,                 // which gpio pins register is chosen
    input wire logic wait_for_addr,                  // selector waits for an address
    input wire logic addr_update,                    // pulse: address word valid
    input wire logic [7:0] addr_value,               // scanned address
    input wire logic resume_ports_cmd,               // pulse: resume-ports executes
    input wire logic counter_load_cmd,               // pulse: counter loaded after load command
    input wire logic counter_zero,                   // pulse: running counter reached zero
    input wire logic bridge_primary_mode,            // bridge primary operating mode
    input wire logic [6:0] port_parked,              // port parked in idle or a pause state
    input wire logic [6:0] parked_reset_state,       // port parked in test-logic-reset
    input wire logic [6:0] local_scan_port_tdi,      // data back from each local port pin
    input wire logic cfg_hold,                       // stalls the write drain
    output logic tdo_b,                              // backplane data out
    output logic [6:0] local_scan_port_tck,          // local test clocks
    output logic [6:0] local_scan_port_tdo,          // data to each local port
    output logic [6:0] gpio_mode,                    // port is in gpio use
    output logic [6:0] gpio_tms,                     // gpio mode-select pin value
    output logic multicast_selected,                 // group address matched
    output logic transparent_mode,                   // transparent port mode active
    output logic [7:0] sel0_out,                     // chain select zero contents
    output logic cfg_ready                           // fifo can take a write
);
    typedef struct packed {
        logic [2:0] tck_s;
        logic [1:0] tms_s;
        logic [1:0] tdi_s;
        logic [1:0][6:0] ltdi_s;
        lsp_pkg::lsp_tap_t tap;
        logic [7:0] sh;
        logic [1:0] multicast_group_reg;
        logic [7:0] sel0;
        logic [7:0] sel1;
        logic [7:0] gsel;
        logic [6:0][7:0] gpins;
        logic [6:0] chain_en;
        logic [6:0] pad;
        logic [6:0][lsp_pkg::TLR_CNT_W-1:0] tlr_cnt;
        logic tdo;
        logic [6:0] ltck;
        logic [6:0] ltdo;
        logic mc_sel;
        logic transp;
        logic rdy;
    } lsp_st_t;

    lsp_st_t st, next_st;
    logic tck_rise, tck_fall;
    logic wr_valid, wr_ready, rd_valid, rd_pop;
    lsp_pkg::lsp_wr_t wr_word, rd_word;
    logic [lsp_pkg::WR_W-1:0] rd_bits;
    logic [7:0] cap_val;
    logic reg_so, src;
    logic [6:0] active;

    // =====================================================================
    // edges seen on the synchronised backplane clock
    assign tck_rise = st.tck_s[1] && !st.tck_s[2];
    assign tck_fall = !st.tck_s[1] && st.tck_s[2];

    // fifo: updates are queued so a stalled drain cannot corrupt the shift path
    assign wr_valid = tck_rise && st.tap == lsp_pkg::TAP_EX1_DR && !st.tms_s[1] ? 1'b0
        : (tck_rise && st.tap == lsp_pkg::TAP_EX1_DR && st.tms_s[1] && dr_sel != lsp_pkg::DR_OTHER)
        || (tck_rise && st.tap == lsp_pkg::TAP_EX2_DR && st.tms_s[1] && dr_sel != lsp_pkg::DR_OTHER);
    assign wr_word = '{target: dr_sel, gpio_idx: gpio_idx, data: st.sh};
    assign rd_word = lsp_pkg::lsp_wr_t'(rd_bits);
    assign rd_pop = rd_valid && !cfg_hold && st.tap != lsp_pkg::TAP_RESET;

    lsp_cfg_fifo #(.WIDTH(lsp_pkg::WR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_word),
        .out_valid(rd_valid),
        .out_ready(rd_pop),
        .out_data(rd_bits)
    );

    // =====================================================================
    // tap controller step
    function automatic lsp_pkg::lsp_tap_t tap_next(input lsp_pkg::lsp_tap_t s, input logic tms);
        case (s)
            lsp_pkg::TAP_RESET: return tms ? lsp_pkg::TAP_RESET : lsp_pkg::TAP_IDLE;
            lsp_pkg::TAP_IDLE: return tms ? lsp_pkg::TAP_SEL_DR : lsp_pkg::TAP_IDLE;
            lsp_pkg::TAP_SEL_DR: return tms ? lsp_pkg::TAP_SEL_IR : lsp_pkg::TAP_CAP_DR;
            lsp_pkg::TAP_CAP_DR: return tms ? lsp_pkg::TAP_EX1_DR : lsp_pkg::TAP_SH_DR;
            lsp_pkg::TAP_SH_DR: return tms ? lsp_pkg::TAP_EX1_DR : lsp_pkg::TAP_SH_DR;
            lsp_pkg::TAP_EX1_DR: return tms ? lsp_pkg::TAP_UPD_DR : lsp_pkg::TAP_PA_DR;
            lsp_pkg::TAP_PA_DR: return tms ? lsp_pkg::TAP_EX2_DR : lsp_pkg::TAP_PA_DR;
            lsp_pkg::TAP_EX2_DR: return tms ? lsp_pkg::TAP_UPD_DR : lsp_pkg::TAP_SH_DR;
            lsp_pkg::TAP_UPD_DR: return tms ? lsp_pkg::TAP_SEL_DR : lsp_pkg::TAP_IDLE;
            lsp_pkg::TAP_SEL_IR: return tms ? lsp_pkg::TAP_RESET : lsp_pkg::TAP_CAP_IR;
            lsp_pkg::TAP_CAP_IR: return tms ? lsp_pkg::TAP_EX1_IR : lsp_pkg::TAP_SH_IR;
            lsp_pkg::TAP_SH_IR: return tms ? lsp_pkg::TAP_EX1_IR : lsp_pkg::TAP_SH_IR;
            lsp_pkg::TAP_EX1_IR: return tms ? lsp_pkg::TAP_UPD_IR : lsp_pkg::TAP_PA_IR;
            lsp_pkg::TAP_PA_IR: return tms ? lsp_pkg::TAP_EX2_IR : lsp_pkg::TAP_PA_IR;
            lsp_pkg::TAP_EX2_IR: return tms ? lsp_pkg::TAP_UPD_IR : lsp_pkg::TAP_SH_IR;
            lsp_pkg::TAP_UPD_IR: return tms ? lsp_pkg::TAP_SEL_DR : lsp_pkg::TAP_IDLE;
            default: return lsp_pkg::TAP_RESET;
        endcase
    endfunction

    // =====================================================================
    // capture value of the chosen register
    always_comb begin
        case (dr_sel)
            lsp_pkg::DR_GROUP: cap_val = {6'h00, st.multicast_group_reg};
            lsp_pkg::DR_SEL0: cap_val = st.sel0;
            lsp_pkg::DR_SEL1: cap_val = st.sel1;
            lsp_pkg::DR_GPIO_SEL: cap_val = st.gsel;
            lsp_pkg::DR_GPIO_PINS: begin
                cap_val = st.gpins[gpio_idx];
                cap_val[lsp_pkg::GPIO_TDI] = st.ltdi_s[1][gpio_idx];
            end
            default: cap_val = 8'h00;
        endcase
    end

    assign reg_so = (dr_sel == lsp_pkg::DR_OTHER) ? st.tdi_s[1] : st.sh[0];
    assign active = st.chain_en & ~port_parked & ~parked_reset_state;

    always_comb begin
        next_st = st;
        src = reg_so;
        // synchronisers: the first stage feeds only the second
        next_st.tck_s = {st.tck_s[1:0], tck_b};
        next_st.tms_s = {st.tms_s[0], tms_b};
        next_st.tdi_s = {st.tdi_s[0], tdi_b};
        next_st.ltdi_s = {st.ltdi_s[0], local_scan_port_tdi};
        next_st.rdy = wr_ready;

        if (tck_rise) begin
            next_st.tap = tap_next(st.tap, st.tms_s[1]);
            // capture on leaving capture-dr, so the captured lsb is the first bit shifted out
            if (st.tap == lsp_pkg::TAP_CAP_DR) begin
                next_st.sh = cap_val;
            end
            if (st.tap == lsp_pkg::TAP_SH_DR) begin
                if (dr_sel == lsp_pkg::DR_GROUP) begin
                    next_st.sh = {6'h00, st.tdi_s[1], st.sh[1]};
                end else begin
                    next_st.sh = {st.tdi_s[1], st.sh[7:1]};
                end
            end
            // pads sample what comes back from each port
            for (int i = 0; i < lsp_pkg::NUM_PORTS; i++) begin
                next_st.pad[i] = st.ltdi_s[1][i];
                if (parked_reset_state[i]) begin
                    if (st.tlr_cnt[i] != lsp_pkg::TLR_CNT_W'(lsp_pkg::TLR_PULSES)) begin
                        next_st.tlr_cnt[i] = st.tlr_cnt[i] + 1'b1;
                    end
                end else begin
                    next_st.tlr_cnt[i] = '0;
                end
            end
        end

        // chain routing, launched on the falling edge
        if (tck_fall) begin
            for (int i = 0; i < lsp_pkg::NUM_PORTS; i++) begin
                if (active[i] && !st.sel0[lsp_pkg::SEL0_LOOP]) begin
                    next_st.ltdo[i] = src;
                    src = st.pad[i];
                end
            end
            next_st.tdo = src;
        end
        // gpio data out is static and must not wait for a test clock edge
        for (int i = 0; i < lsp_pkg::NUM_PORTS; i++) begin
            if (st.gsel[i]) begin
                next_st.ltdo[i] = st.gpins[i][lsp_pkg::GPIO_TDO];
            end
        end

        // clock gating per port
        for (int i = 0; i < lsp_pkg::NUM_PORTS; i++) begin
            if (parked_reset_state[i]) begin
                next_st.ltck[i] = (st.tlr_cnt[i] == lsp_pkg::TLR_CNT_W'(lsp_pkg::TLR_PULSES)) ? 1'b0
                    : st.tck_s[1];
            end else if (port_parked[i] && st.sel0[lsp_pkg::SEL0_CLK_DIS]) begin
                next_st.ltck[i] = 1'b0;
            end else begin
                next_st.ltck[i] = st.tck_s[1];
            end
        end

        if (resume_ports_cmd) begin
            next_st.chain_en = lsp_pkg::port_enables(st.sel0, st.sel1);
        end

        // applied only from the update queue, so shifting never disturbs live values
        if (rd_pop) begin
            case (rd_word.target)
                lsp_pkg::DR_GROUP: next_st.multicast_group_reg = rd_word.data[1:0];
                lsp_pkg::DR_SEL0: begin
                    next_st.sel0[6:0] = rd_word.data[6:0];
                end
                lsp_pkg::DR_SEL1: next_st.sel1 = rd_word.data & 8'h83;
                lsp_pkg::DR_GPIO_SEL: next_st.gsel = rd_word.data & 8'h7f;
                lsp_pkg::DR_GPIO_PINS: begin
                    if (rd_word.gpio_idx < 3'h7) begin
                        next_st.gpins[rd_word.gpio_idx] = rd_word.data & 8'h83;
                    end
                end
                default: next_st.sel0 = next_st.sel0;
            endcase
        end

        // status bit: a zero pulse beats a load pulse in the same cycle
        if (counter_load_cmd) begin
            next_st.sel0[lsp_pkg::SEL0_CNT_STAT] = 1'b0;
        end
        if (counter_zero) begin
            next_st.sel0[lsp_pkg::SEL0_CNT_STAT] = 1'b1;
        end

        next_st.mc_sel = wait_for_addr && addr_update && addr_value[7:2] == lsp_pkg::MC_BASE[7:2]
            && addr_value[1:0] == st.multicast_group_reg ? 1'b1
            : (addr_update ? 1'b0 : st.mc_sel);
        next_st.transp = st.sel1[lsp_pkg::SEL1_TRANSP] && bridge_primary_mode;

        if (st.tap == lsp_pkg::TAP_RESET) begin
            next_st.sel0 = lsp_pkg::SEL0_RESET;
            next_st.sel1 = lsp_pkg::SEL1_RESET;
            next_st.gsel = lsp_pkg::GPIO_SEL_RESET;
            next_st.gpins = {lsp_pkg::NUM_PORTS{lsp_pkg::GPIO_PINS_RESET}};
            next_st.multicast_group_reg = lsp_pkg::GROUP_RESET;
            next_st.chain_en = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st <= '0;
            st.tap <= lsp_pkg::TAP_RESET;
            st.sel0 <= lsp_pkg::SEL0_RESET;
        end else begin
            st <= next_st;
        end
    end

    // =====================================================================
    // outputs, all straight from state flops
    assign tdo_b = st.tdo;
    assign local_scan_port_tck = st.ltck;
    assign local_scan_port_tdo = st.ltdo;
    assign gpio_mode = st.gsel[6:0];
    always_comb begin
        for (int i = 0; i < lsp_pkg::NUM_PORTS; i++) begin
            gpio_tms[i] = st.gpins[i][lsp_pkg::GPIO_TMS];
        end
    end
    assign multicast_selected = st.mc_sel;
    assign transparent_mode = st.transp;
    assign sel0_out = st.sel0;
    assign cfg_ready = st.rdy;

    // =====================================================================
    // checks
    a_reset_loads_sel0:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        st.tap == lsp_pkg::TAP_RESET && !counter_zero |=> st.sel0 == lsp_pkg::SEL0_RESET)
        else $error("select zero not loaded in reset state");

    a_reset_defaults:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        st.tap == lsp_pkg::TAP_RESET |=> st.sel1 == 8'h00 && st.gsel == 8'h00 && st.gpins == '0)
        else $error("mode registers not defaulted");

    a_status_set:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        counter_zero |=> st.sel0[lsp_pkg::SEL0_CNT_STAT])
        else $error("status bit not set on zero");

    a_status_clear:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        counter_load_cmd && !counter_zero |=> !st.sel0[lsp_pkg::SEL0_CNT_STAT])
        else $error("status bit not cleared on load");

    a_clock_stopped:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        port_parked[1] && !parked_reset_state[1] && st.sel0[lsp_pkg::SEL0_CLK_DIS]
        |=> !local_scan_port_tck[1])
        else $error("parked clock not held low");

    a_unparked_runs:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        !port_parked[0] && !parked_reset_state[0] |=> local_scan_port_tck[0] == $past(st.tck_s[1]))
        else $error("unparked clock gated");

    a_tlr_stop:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        parked_reset_state[2] && st.tlr_cnt[2] == 10'h200 |=> !local_scan_port_tck[2])
        else $error("reset-parked clock not stopped after 512");

    a_loop_bypass:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        tck_fall && st.sel0[lsp_pkg::SEL0_LOOP] |=> tdo_b == $past(reg_so))
        else $error("loopback chain wrong");

    a_multicast_match:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        addr_update && wait_for_addr && addr_value == (lsp_pkg::MC_BASE | {6'h00, st.multicast_group_reg})
        |=> multicast_selected)
        else $error("matching group not selected");

    a_transparent_gate:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        !bridge_primary_mode |=> !transparent_mode)
        else $error("transparent mode outside bridge mode");

    c_update_write: cover property (@(posedge sys_clk) disable iff (!rst_n) rd_pop);
    c_resume: cover property (@(posedge sys_clk) disable iff (!rst_n) resume_ports_cmd && |st.sel0[2:0]);
    c_fifo_full: cover property (@(posedge sys_clk) disable iff (!rst_n) !wr_ready);
    c_mc_hit: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(multicast_selected));
endmodule // lsp_cfg

// ---- lsp_pkg.sv ----
// shared types and constants of the local scan port configuration block
package lsp_pkg;

    // =====================================================================
    // backplane tap controller states and data register selection
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
        TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
    } lsp_tap_t;

    typedef enum logic [2:0] {
        DR_OTHER, DR_GROUP, DR_SEL0, DR_SEL1, DR_GPIO_SEL, DR_GPIO_PINS
    } lsp_dr_t;

    // =====================================================================
    // sizes and reset values
    localparam int NUM_PORTS = 7;
    localparam int REG_W = 8;
    localparam int GROUP_W = 2;
    localparam int TLR_PULSES = 512;
    localparam int TLR_CNT_W = 10;
    localparam logic [7:0] SEL0_RESET = 8'h01;
    localparam logic [7:0] SEL1_RESET = 8'h00;
    localparam logic [7:0] GPIO_SEL_RESET = 8'h00;
    localparam logic [7:0] GPIO_PINS_RESET = 8'h00;
    localparam logic [1:0] GROUP_RESET = 2'h0;

    // =====================================================================
    // field positions
    localparam int SEL0_CLK_DIS = 3;
    localparam int SEL0_LOOP = 4;
    localparam int SEL0_CNT_STAT = 7;
    localparam int SEL1_TRANSP = 7;
    localparam int GPIO_TMS = 0;
    localparam int GPIO_TDO = 1;
    localparam int GPIO_TDI = 2;

    // group code n answers at multicast address MC_BASE + n
    localparam logic [7:0] MC_BASE = 8'h3c;

    // =====================================================================
    // a configuration write that waits in the fifo
    typedef struct packed {
        lsp_dr_t target;
        logic [2:0] gpio_idx;
        logic [7:0] data;
    } lsp_wr_t;

    localparam int WR_W = $bits(lsp_wr_t);

    // port enables in port order from the two chain select registers
    function automatic logic [6:0] port_enables(input logic [7:0] sel0, input logic [7:0] sel1);
        return {sel1[1], sel1[0], sel0[6], sel0[5], sel0[2], sel0[1], sel0[0]};
    endfunction

endpackage

// ---- lsp_scan_ctl.sv ----
// backplane scan controller model driving the test port pins
`timescale 1ns/1ns
module lsp_scan_ctl (
    input wire logic sys_clk, // system clock
    output logic tck_b,       // backplane test clock
    output logic tms_b,       // backplane mode select
    output logic tdi_b        // backplane data in
);
    initial begin
        tck_b = 1'b0;
        tms_b = 1'b0;
        tdi_b = 1'b0;
    end
    // one tck period of 8 sys_clk, pins change while tck is low
    task automatic tick(input logic t, input logic d);
        @(posedge sys_clk);
        tck_b <= 1'b0;
        tms_b <= t;
        tdi_b <= d;
        repeat (4) @(posedge sys_clk);
        tck_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask
    // data register write, lsb first; config only ever reached this way
    task automatic scan(input logic [7:0] v, input int n);
        tick(1'b0, 1'b0);
        tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
        tick(1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, v[i]);
        end
        tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
        // clock stands low between frames, data line no longer holds its value
        @(posedge sys_clk);
        tck_b <= 1'b0;
        tdi_b <= ~tdi_b;
    endtask
endmodule // lsp_scan_ctl

// ---- tb_local_scan_port_config.sv ----
// testbench of the local scan port configuration block
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_local_scan_port_config;
    logic sys_clk = 1'b0, rst_n = 1'b0, tck_b, tms_b, tdi_b, wait_for_addr = 1'b0, addr_update = 1'b0;
    logic counter_load_cmd = 1'b0, counter_zero = 1'b0, bridge_primary_mode = 1'b0, cfg_hold = 1'b0, clr = 1'b1;
    lsp_pkg::lsp_dr_t dr_sel = lsp_pkg::DR_OTHER;
    logic [2:0] gpio_idx = 3'h0;
    logic [7:0] addr_value = 8'h00, sel0_out;
    logic [6:0] port_parked = 7'h00, seen, lp_tck, gpio_mode, gpio_tms, lp_tdo, park_rst = 7'h00, port_tdi = 7'h00;
    logic multicast_selected, transparent_mode, tdo_b, cfg_ready, resume = 1'b0;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    always #5 sys_clk = ~sys_clk;
    lsp_scan_ctl ctl (.sys_clk(sys_clk), .tck_b(tck_b), .tms_b(tms_b), .tdi_b(tdi_b));
    lsp_cfg dut (.sys_clk(sys_clk), .rst_n(rst_n), .tck_b(tck_b), .tms_b(tms_b), .tdi_b(tdi_b),
        .dr_sel(dr_sel), .gpio_idx(gpio_idx), .wait_for_addr(wait_for_addr), .addr_update(addr_update),
        .addr_value(addr_value), .resume_ports_cmd(resume), .counter_load_cmd(counter_load_cmd),
        .counter_zero(counter_zero), .bridge_primary_mode(bridge_primary_mode), .port_parked(port_parked),
        .parked_reset_state(park_rst), .local_scan_port_tdi(port_tdi), .cfg_hold(cfg_hold), .tdo_b(tdo_b),
        .local_scan_port_tck(lp_tck), .local_scan_port_tdo(lp_tdo), .gpio_mode(gpio_mode), .gpio_tms(gpio_tms),
        .multicast_selected(multicast_selected), .transparent_mode(transparent_mode), .sel0_out(sel0_out),
        .cfg_ready(cfg_ready));
    // which local clocks were seen high since the last clear
    always @(posedge sys_clk) seen <= clr ? 7'h00 : (seen | lp_tck);
    // =====================================================================
    // helpers
    task automatic wr(input lsp_pkg::lsp_dr_t r, input logic [7:0] v, input int n);
        dr_sel <= r;
        ctl.scan(v, n);
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic mc(input logic [7:0] a, input logic e);
        addr_value <= a;
        addr_update <= 1'b1;
        @(posedge sys_clk);
        addr_update <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHK(multicast_selected, e)
    endtask
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // eight scans plus the 512-clock reset park
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            print_verdict;
        end
    end
    // =====================================================================
    // sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK(sel0_out, 8'h01)
        `CHK(cfg_ready, 1'b1)
        `CHK(gpio_mode, 7'h00)
        `CHK(transparent_mode, 1'b0)
        wait_for_addr <= 1'b1;
        for (int g = 0; g < 4; g++) begin
            wr(lsp_pkg::DR_GROUP, 8'(g), 2);
            mc(8'h3c + 8'((g + 1) % 4), 1'b0);
            mc(8'h3c + 8'(g), 1'b1);
        end
        // a held drain must keep the old value in force
        cfg_hold <= 1'b1;
        wr(lsp_pkg::DR_SEL0, 8'h18, 8);
        `CHK(sel0_out, 8'h01)
        cfg_hold <= 1'b0;
        repeat (8) @(posedge sys_clk);
        `CHK(sel0_out, 8'h18)
        counter_zero <= 1'b1;
        @(posedge sys_clk);
        counter_zero <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHK(sel0_out, 8'h98)
        counter_load_cmd <= 1'b1;
        @(posedge sys_clk);
        counter_load_cmd <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHK(sel0_out, 8'h18)
        port_parked <= 7'h02;
        bridge_primary_mode <= 1'b1;
        clr <= 1'b0;
        wr(lsp_pkg::DR_SEL1, 8'h80, 8);
        `CHK(seen[1:0], 2'b01)
        `CHK(transparent_mode, 1'b1)
        bridge_primary_mode <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(transparent_mode, 1'b0)
        wr(lsp_pkg::DR_GPIO_SEL, 8'h05, 8);
        `CHK(gpio_mode, 7'h05)
        gpio_idx <= 3'h2;
        wr(lsp_pkg::DR_GPIO_PINS, 8'h03, 8);
        `CHK(gpio_tms, 7'h04)
        `CHK(lp_tdo, 7'h04)
        // park port 2 in reset and walk the backplane into reset as well
        park_rst <= 7'h04;
        repeat (512) ctl.tick(1'b1, 1'b0);
        clr <= 1'b1;
        repeat (2) @(posedge sys_clk);
        clr <= 1'b0;
        repeat (4) ctl.tick(1'b1, 1'b0);
        `CHK(seen, 7'h7b)
        `CHK(sel0_out, 8'h01)
        `CHK(gpio_mode, 7'h00)
        // port 0 in the chain: tdi reaches its data out, its data in reaches tdo after the pad
        dr_sel <= lsp_pkg::DR_OTHER;
        ctl.tick(1'b0, 1'b0);
        resume <= 1'b1;
        @(posedge sys_clk);
        resume <= 1'b0;
        repeat (2) ctl.tick(1'b0, 1'b1);
        `CHK({tdo_b, lp_tdo[0]}, 2'b01)
        port_tdi <= 7'h01;
        repeat (2) ctl.tick(1'b0, 1'b0);
        `CHK({tdo_b, lp_tdo[0]}, 2'b10)
        print_verdict;
    end
endmodule // tb_local_scan_port_config
